// ---- inc/pcrb_consts.svh ----
// Constants of the synthesizer control register bank: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PCRB_CONSTS_SVH
`define PCRB_CONSTS_SVH

`define PCRB_DATA_W        24
`define PCRB_FRAME_W       32
`define PCRB_CNT_W         6
`define PCRB_ADDR_ID       5'h00
`define PCRB_ADDR_PWR      5'h01
`define PCRB_ADDR_REF      5'h02
`define PCRB_ADDR_INT      5'h03
`define PCRB_SRST_BIT      5
`define PCRB_PWR_SRC_BIT   0
`define PCRB_PWR_EN_BIT    1
`define PCRB_KEEP_LSB      2
`define PCRB_KEEP_N        6
`define PCRB_PWR_RST       24'h000003
`define PCRB_REF_RST       24'h000001
`define PCRB_INT_RST       24'h000019
`define PCRB_REF_MIN       14'h0001
`define PCRB_INT_FRAC_MIN  19'h00014
`define PCRB_INT_FRAC_MAX  19'h7FFFC
`define PCRB_INT_INTG_MIN  19'h00010
`define PCRB_CHIP_ADDR     3'h0
// Identification word: value is arbitrary
`define PCRB_DEV_ID        24'h5A3C01

`endif

// ---- inc/pcrb_link_if.sv ----
// Carrier between the register core and the serial shifter.
// Frame and read word are quasi-static while the other side samples them.
`timescale 1ns/1ps
`default_nettype none
interface pcrb_link_if;
   pcrb_pkg::pcrb_frame_t frame;
   logic [23:0]           rd_word;
   logic                  sdo;
   modport core    (input frame, input sdo, output rd_word);
   modport shifter (output frame, output sdo, input rd_word);
endinterface : pcrb_link_if
`default_nettype wire

// ---- inc/pcrb_pkg.sv ----
// Types of the synthesizer control register bank.
// Assumes pcrb_consts.svh on the include path.
`include "pcrb_consts.svh"
package pcrb_pkg;
   typedef struct packed {
      logic [23:0] data;
      logic [4:0]  addr;
      logic [2:0]  chip;
   } pcrb_frame_t;

   typedef struct packed {
      logic [23:0] pwr;
      logic [23:0] refd;
      logic [23:0] intg;
      logic [4:0]  ptr;
      logic [23:0] rd;
      logic        sen_d;
      logic        cen;
      logic [5:0]  blk;
      logic        ref_err;
      logic        int_err;
   } pcrb_core_t;

   typedef struct packed {
      logic [5:0]  cnt;
      logic [23:0] osr;
      logic        sdo;
   } pcrb_out_t;
endpackage : pcrb_pkg

// ---- src/pcrb_bank.sv ----
// Control register bank of the synthesizer, reached through the serial frame.
// Assumes a host that stops the serial clock between frames and keeps the strobe low in frames.
//
// Behaviour
// - Address zero reads a fixed 24-bit identification word; writes never alter it.
// - Write to address zero with bit 5 clear stores bits 4..0 as read pointer for next frame.
// - Enable source 1: power follows enable pin, pin low means power down.
// - Enable source 0: pin ignored, register enable bit sets power state.
// - Bits 2..7 each keep one block powered regardless of enable state.
// - Reference divide is bits 13..0 of address 2; legal 1 to 3FFFh.
// - Integer divide is bits 18..0 of address 3; fractional range 14h..7FFFCh.
// - Power enable register resets to 3h.
// - Integer divider register resets to 19h, spare bits clear.
// - Serial out shifts the register named by previously stored read pointer.
// - Frame is 24 data, 5 address, 3 chip bits, MSB first, rising edges.
`timescale 1ns/1ps
`default_nettype none
`include "pcrb_consts.svh"
module pcrb_bank (
   input  wire logic        I_SYS_CLK,      // System clock, 20 MHz
   input  wire logic        I_ARST_N,       // Async reset, active low
   input  wire logic        I_SCK,          // Serial clock from host
   input  wire logic        I_SDI,          // Serial in line
   input  wire logic        I_SEN,          // Serial latch strobe
   input  wire logic        I_CHIP_EN,      // External power control pin
   input  wire logic        I_FRAC_MODE,    // 1 = fractional operation
   output logic             O_LOCK_OR_SERIAL_OUT_PIN,       // Lock or serial out pin
   output logic             O_CHIP_ENABLED, // Device powered
   output logic [5:0]       O_BLOCK_ON,     // Per block power: bias..output driver
   output logic [13:0]      O_REF_DIV,      // Reference divide value
   output logic [18:0]      O_INT_DIV,      // Integer divide value
   output logic             O_REF_ERR,      // Reference divide out of range
   output logic             O_INT_ERR       // Integer divide out of range
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and synchronisers

   logic [1:0] rst_ff;
   logic       rst_n;
   logic       frame_rst_n;
   logic [1:0] pin_s;
   logic       sen_s;
   logic       chip_en_s;

   always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) rst_ff <= 2'h0;
      else           rst_ff <= {rst_ff[0], 1'b1};
   end
   assign rst_n = rst_ff[1];

   // The strobe ends the frame on the serial side even with the serial clock stopped
   assign frame_rst_n = rst_n & ~I_SEN;

   pcrb_sync #(.W(2)) u_sync (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (rst_n),
      .i_d     ({I_SEN, I_CHIP_EN}),
      .o_q     (pin_s)
   );
   assign sen_s     = pin_s[1];
   assign chip_en_s = pin_s[0];

   ////////////////////////////////////////////////////////////////////////////
   // Serial side

   pcrb_link_if link ();

   pcrb_shifter u_shift (
      .i_sck         (I_SCK),
      .i_rst_n       (rst_n),
      .i_frame_rst_n (frame_rst_n),
      .i_sdi         (I_SDI),
      .link          (link.shifter)
   );

   assign O_LOCK_OR_SERIAL_OUT_PIN = link.sdo;

   ////////////////////////////////////////////////////////////////////////////
   // Register core

   pcrb_pkg::pcrb_core_t s;
   pcrb_pkg::pcrb_core_t n;
   logic                 commit;
   logic                 wr_id;
   logic                 srst;
   logic [23:0]          rd_sel;
   logic                 en_now;

   // Frame is stable here: the host stops the clock before raising the strobe
   assign commit = sen_s & ~s.sen_d & (link.frame.chip == `PCRB_CHIP_ADDR);
   assign wr_id  = commit & (link.frame.addr == `PCRB_ADDR_ID);
   assign srst   = wr_id & link.frame.data[`PCRB_SRST_BIT];

   always_comb begin
      case (s.ptr)
         `PCRB_ADDR_ID:  rd_sel = `PCRB_DEV_ID;
         `PCRB_ADDR_PWR: rd_sel = s.pwr;
         `PCRB_ADDR_REF: rd_sel = s.refd;
         `PCRB_ADDR_INT: rd_sel = s.intg;
         default:        rd_sel = 24'h000000;
      endcase
   end

   // Pin decides only when the source bit selects it
   assign en_now = s.pwr[`PCRB_PWR_SRC_BIT] ? chip_en_s
                                            : s.pwr[`PCRB_PWR_EN_BIT];

   always_comb begin
      n       = s;
      n.sen_d = sen_s;
      if (srst) begin
         n.pwr  = `PCRB_PWR_RST;
         n.refd = `PCRB_REF_RST;
         n.intg = `PCRB_INT_RST;
         n.ptr  = `PCRB_ADDR_ID;
      end else if (commit) begin
         case (link.frame.addr)
            `PCRB_ADDR_ID:  n.ptr  = link.frame.data[4:0];
            `PCRB_ADDR_PWR: n.pwr  = link.frame.data;
            `PCRB_ADDR_REF: n.refd = link.frame.data;
            `PCRB_ADDR_INT: n.intg = link.frame.data;
            default:        n.ptr  = s.ptr;
         endcase
      end
      n.rd  = rd_sel;
      n.cen = en_now;
      n.blk = s.pwr[`PCRB_KEEP_LSB +: `PCRB_KEEP_N] | {`PCRB_KEEP_N{en_now}};
      n.ref_err = (s.refd[13:0] < `PCRB_REF_MIN);
      if (I_FRAC_MODE) begin
         n.int_err = (s.intg[18:0] < `PCRB_INT_FRAC_MIN) ||
                     (s.intg[18:0] > `PCRB_INT_FRAC_MAX);
      end else begin
         n.int_err = (s.intg[18:0] < `PCRB_INT_INTG_MIN);
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s       <= '0;
         s.pwr   <= `PCRB_PWR_RST;
         s.refd  <= `PCRB_REF_RST;
         s.intg  <= `PCRB_INT_RST;
         s.rd    <= `PCRB_DEV_ID;
         s.cen   <= 1'b0;
      end else begin
         s <= n;
      end
   end

   assign link.rd_word   = s.rd;
   assign O_CHIP_ENABLED = s.cen;
   assign O_BLOCK_ON     = s.blk;
   assign O_REF_DIV      = s.refd[13:0];
   assign O_INT_DIV      = s.intg[18:0];
   assign O_REF_ERR      = s.ref_err;
   assign O_INT_ERR      = s.int_err;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_id_read_fixed: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.ptr == `PCRB_ADDR_ID) |=> (s.rd == `PCRB_DEV_ID))
      else $error("Identification word not presented");

   a_ptr_store: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (wr_id && !srst)
      |=> ##1 (s.rd == $past(rd_sel)) && (s.ptr == $past(link.frame.data[4:0], 2)))
      else $error("Read pointer not stored");

   a_pin_power_down: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.pwr[0] && !chip_en_s) |=> !s.cen)
      else $error("Pin low did not power down");

   a_reg_enable: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (!s.pwr[0] && !commit) |=> (s.cen == s.pwr[1]))
      else $error("Register enable not followed");

   a_keep_alive: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.pwr[7:2] != 6'h00) |=> ((s.blk & $past(s.pwr[7:2])) == $past(s.pwr[7:2])))
      else $error("Keep-alive block not powered");

   a_ref_zero_flag: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.refd[13:0] == 14'h0000) |=> O_REF_ERR)
      else $error("Zero reference divide not flagged");

   a_int_frac_range: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (I_FRAC_MODE && s.intg[18:0] > `PCRB_INT_FRAC_MAX) |=> O_INT_ERR)
      else $error("Integer divide above fractional range not flagged");

   a_reset_values: assert property (@(posedge I_SYS_CLK)
      $rose(rst_n) |-> (s.pwr == `PCRB_PWR_RST) && (s.refd == `PCRB_REF_RST)
                       && (s.intg == `PCRB_INT_RST))
      else $error("Register reset value wrong");

   a_soft_reset: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      srst |=> (s.pwr == `PCRB_PWR_RST) && (s.refd == `PCRB_REF_RST)
               && (s.intg == `PCRB_INT_RST) && (s.ptr == 5'h00))
      else $error("Soft reset did not restore registers");

   a_spare_stored: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (commit && !srst && link.frame.addr == `PCRB_ADDR_REF)
      |=> (s.refd == $past(link.frame.data)))
      else $error("Reference register not stored as written");

   a_int_written: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (commit && link.frame.addr == `PCRB_ADDR_INT)
      |=> ##1 (O_INT_DIV == $past(link.frame.data[18:0], 2)))
      else $error("Integer register write lost");

   ////////////////////////////////////////////////////////////////////////////
   // Register paths, power and range flags

   a_id_write_keep: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (wr_id && !srst)
      |=> (s.pwr == $past(s.pwr)) && (s.refd == $past(s.refd)) && (s.intg == $past(s.intg)))
      else $error("Address zero write changed a register");

   a_ptr_hold: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      !commit
      |=> (s.ptr == $past(s.ptr)))
      else $error("Read pointer changed without a write");

   a_ptr_other_addr: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (commit && (link.frame.addr != `PCRB_ADDR_ID))
      |=> (s.ptr == $past(s.ptr)))
      else $error("Read pointer changed by another address");

   a_rd_pwr_word: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.ptr == `PCRB_ADDR_PWR)
      |=> (s.rd == $past(s.pwr)))
      else $error("Read word does not show the power register");

   a_rd_ref_word: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.ptr == `PCRB_ADDR_REF)
      |=> (s.rd == $past(s.refd)))
      else $error("Read word does not show the reference register");

   a_rd_int_word: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.ptr == `PCRB_ADDR_INT)
      |=> (s.rd == $past(s.intg)))
      else $error("Read word does not show the integer register");

   a_rd_unused_zero: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.ptr > `PCRB_ADDR_INT)
      |=> (s.rd == 24'h000000))
      else $error("Unused address does not read zero");

   a_pin_power_up: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.pwr[`PCRB_PWR_SRC_BIT] && chip_en_s)
      |=> s.cen)
      else $error("Pin high did not power up");

   a_blk_all_on: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      s.cen
      |-> (s.blk == 6'h3F))
      else $error("Enabled device left a block off");

   a_blk_track: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      1'b1
      |=> (s.blk == ($past(s.pwr[7:2]) | {6{s.cen}})))
      else $error("Block power differs from keep bits and enable");

   // One check per block, so a failure names the block that dropped
   for (genvar b = 0; b < `PCRB_KEEP_N; b++) begin : g_keep
      a_keep_block: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
         s.pwr[`PCRB_KEEP_LSB + b] |=> s.blk[b])
         else $error("Kept block not powered");
   end

   a_pwr_written: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (commit && (link.frame.addr == `PCRB_ADDR_PWR))
      |=> (s.pwr == $past(link.frame.data)))
      else $error("Power register not stored as written");

   a_int_stored: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (commit && (link.frame.addr == `PCRB_ADDR_INT))
      |=> (s.intg == $past(link.frame.data)))
      else $error("Integer register not stored as written");

   a_regs_hold: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      !commit
      |=> (s.pwr == $past(s.pwr)) && (s.refd == $past(s.refd)) && (s.intg == $past(s.intg)))
      else $error("Register changed without a write");

   a_ref_ok_clear: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (s.refd[13:0] != 14'h0000)
      |=> !O_REF_ERR)
      else $error("Legal reference divide flagged");

   a_int_frac_low: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (I_FRAC_MODE && (s.intg[18:0] < `PCRB_INT_FRAC_MIN))
      |=> O_INT_ERR)
      else $error("Integer divide below fractional range not flagged");

   a_int_frac_ok: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (I_FRAC_MODE && (s.intg[18:0] >= `PCRB_INT_FRAC_MIN)
       && (s.intg[18:0] <= `PCRB_INT_FRAC_MAX))
      |=> !O_INT_ERR)
      else $error("Legal fractional integer divide flagged");

   a_int_intg_low: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (!I_FRAC_MODE && (s.intg[18:0] < `PCRB_INT_INTG_MIN))
      |=> O_INT_ERR)
      else $error("Integer divide below integer range not flagged");

   a_int_intg_ok: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (!I_FRAC_MODE && (s.intg[18:0] >= `PCRB_INT_INTG_MIN))
      |=> !O_INT_ERR)
      else $error("Legal integer mode divide flagged");

   a_chip_filter: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (sen_s && !s.sen_d && (link.frame.chip != `PCRB_CHIP_ADDR))
      |=> (s.pwr == $past(s.pwr)) && (s.ptr == $past(s.ptr)))
      else $error("Frame for another chip was taken");

   a_commit_single: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      commit
      |=> !commit)
      else $error("One strobe committed twice");

   a_srst_id_word: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      srst
      |=> ##1 (s.rd == `PCRB_DEV_ID))
      else $error("Soft reset did not select the identification word");

   a_reset_quiet: assert property (@(posedge I_SYS_CLK)
      $rose(rst_n)
      |-> !O_CHIP_ENABLED && (O_BLOCK_ON == 6'h00) && (s.ptr == 5'h00))
      else $error("Outputs not quiet after reset");

   a_ref_reset: assert property (@(posedge I_SYS_CLK)
      $rose(rst_n)
      |-> (O_REF_DIV == 14'h0001) && (s.refd[23:14] == 10'h000))
      else $error("Reference divider reset value wrong");

   a_int_reset: assert property (@(posedge I_SYS_CLK)
      $rose(rst_n)
      |-> (O_INT_DIV == 19'h00019) && (s.intg[23:19] == 5'h00))
      else $error("Integer divider reset value wrong");

endmodule : pcrb_bank
`default_nettype wire

// ---- src/pcrb_shifter.sv ----
// Serial shifter on the serial clock: shifts the frame in, read data out.
// Assumes the serial clock stops outside frames; the strobe clears the bit count.
`timescale 1ns/1ps
`default_nettype none
module pcrb_shifter (
   input  wire logic   i_sck,        // Serial clock
   input  wire logic   i_rst_n,      // Bank reset, active low
   input  wire logic   i_frame_rst_n,// Low while the latch strobe is high
   input  wire logic   i_sdi,        // Serial data in
   pcrb_link_if.shifter link         // To the register core
);
   logic [31:0]        sr;
   pcrb_pkg::pcrb_out_t s;
   pcrb_pkg::pcrb_out_t n;

   // Kept apart from the counter: the strobe must not clear the frame it commits
   always_ff @(posedge i_sck or negedge i_rst_n) begin
      if (!i_rst_n) sr <= '0;
      else          sr <= {sr[30:0], i_sdi};
   end
   assign link.frame = sr;

   always_comb begin
      n = s;
      if (s.cnt != 6'h20) n.cnt = s.cnt + 6'h01;
      if (s.cnt == 6'h00) begin
         n.sdo = link.rd_word[23];
         n.osr = {link.rd_word[22:0], 1'b0};
      end else begin
         n.sdo = (s.cnt < 6'h18) ? s.osr[23] : 1'b0;
         n.osr = {s.osr[22:0], 1'b0};
      end
   end

   always_ff @(posedge i_sck or negedge i_frame_rst_n) begin
      if (!i_frame_rst_n) s <= '0;
      else                s <= n;
   end
   assign link.sdo = s.sdo;

   a_sdo_first_bit: assert property (@(posedge i_sck) disable iff (!i_frame_rst_n)
      (s.cnt == 6'h00) |=> (s.sdo == $past(link.rd_word[23])))
      else $error("First read bit not taken from read word");
   a_sdi_msb_first: assert property (@(posedge i_sck) disable iff (!i_rst_n)
      1'b1 |=> ##7 (sr[7] == $past(i_sdi, 8)))
      else $error("Serial input not shifted in order");
endmodule : pcrb_shifter
`default_nettype wire

// ---- src/pcrb_sync.sv ----
// Two flip-flop synchroniser for independent levels.
// Assumes each bit is a level that holds for several destination clocks.
`timescale 1ns/1ps
`default_nettype none
module pcrb_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,   // Destination clock
   input  wire logic         i_rst_n, // Async reset, active low
   input  wire logic [W-1:0] i_d,     // Asynchronous levels
   output logic      [W-1:0] o_q      // Synchronised levels
);
   logic [W-1:0] meta;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= '0;
         o_q  <= '0;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule : pcrb_sync
`default_nettype wire

// ---- testbench/pcrb_host_model.sv ----
// Host serial master model: shifts 32-bit frames MSB first, captures read data.
// Assumes the bank samples on the serial clock rise; the clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module pcrb_host_model (
   output logic      o_sck, // Serial clock, runs only within frames
   output logic      o_sdi, // Serial data to the bank
   output logic      o_sen, // Latch strobe
   input  wire logic i_sdo  // Serial read data
);
   logic [23:0] rd;
   event        done;
   initial begin
      o_sck = 1'b0;
      o_sdi = 1'b0;
      o_sen = 1'b0;
   end
   task automatic send(input logic [31:0] f);
      for (int i = 31; i >= 0; i--) begin
         o_sdi = f[i];
         #16 o_sck = 1'b1;
         #8 if (i >= 8) rd[i-8] = i_sdo;
         #8 o_sck = 1'b0;
      end
      #16 o_sen = 1'b1;
      // Released line must not keep its last bit
      o_sdi = ~o_sdi;
      #250 o_sen = 1'b0;
      #300 -> done;
   endtask : send
endmodule : pcrb_host_model
`default_nettype wire

// ---- testbench/test_pcrb_bank.sv ----
// Self-checking bench of the register bank: every frame checks read data and outputs.
// Assumes the host model makes the serial clock; expected values come from a local model.
`timescale 1ns/1ps
`default_nettype none
`include "pcrb_consts.svh"
module test_pcrb_bank;
   logic        I_SYS_CLK = 1'b0;
   logic        I_ARST_N = 1'b0;
   logic        I_CHIP_EN = 1'b0;
   logic        I_FRAC_MODE = 1'b1;
   logic        sck, serial_in_line, serial_latch_strobe, O_LOCK_OR_SERIAL_OUT_PIN, O_CHIP_ENABLED, O_REF_ERR, O_INT_ERR;
   logic [5:0]  O_BLOCK_ON;
   logic [13:0] O_REF_DIV;
   logic [18:0] O_INT_DIV;
   logic [23:0] pwr, refd, intg;
   logic [4:0]  ptr;
   logic [23:0] q_rd [$];
   logic [41:0] q_st [$];
   logic [24:0] iv [8] = '{25'h1000013, 25'h1000014, 25'h17FFFFC, 25'h17FFFFD,
                           25'h000000F, 25'h0000010, 25'h007FFFF, 25'h1F80019};
   int          bad_count = 0;
   int          compares = 0;
   int          seed = 32'h6A10;
   always #25 I_SYS_CLK = ~I_SYS_CLK;
   pcrb_bank u_pcrb_bank (.I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .I_SCK(sck),
      .I_SDI(serial_in_line), .I_SEN(serial_latch_strobe), .I_CHIP_EN(I_CHIP_EN), .I_FRAC_MODE(I_FRAC_MODE),
      .O_LOCK_OR_SERIAL_OUT_PIN(O_LOCK_OR_SERIAL_OUT_PIN), .O_CHIP_ENABLED(O_CHIP_ENABLED), .O_BLOCK_ON(O_BLOCK_ON),
      .O_REF_DIV(O_REF_DIV), .O_INT_DIV(O_INT_DIV), .O_REF_ERR(O_REF_ERR),
      .O_INT_ERR(O_INT_ERR));
   pcrb_host_model u_pcrb_host_model (.o_sck(sck), .o_sdi(serial_in_line), .o_sen(serial_latch_strobe),
      .i_sdo(O_LOCK_OR_SERIAL_OUT_PIN));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [23:0] rdval(input logic [4:0] p);
      case (p)
         5'h00:   return `PCRB_DEV_ID;
         5'h01:   return pwr;
         5'h02:   return refd;
         5'h03:   return intg;
         default: return 24'h000000;
      endcase
   endfunction : rdval
   function automatic logic [41:0] stval();
      logic        en;
      logic [18:0] n;
      en = pwr[0] ? I_CHIP_EN : pwr[1];
      n  = intg[18:0];
      return {en, pwr[7:2] | {6{en}}, refd[13:0], n, refd[13:0] == 14'h0000,
              I_FRAC_MODE ? (n < 19'h00014 || n > 19'h7FFFC) : (n < 19'h00010)};
   endfunction : stval
   task automatic rst_regs();
      pwr  = `PCRB_PWR_RST;
      refd = `PCRB_REF_RST;
      intg = `PCRB_INT_RST;
      ptr  = 5'h00;
   endtask : rst_regs
   task automatic setin(input logic pin, input logic frac);
      @(posedge I_SYS_CLK);
      I_CHIP_EN   <= pin;
      I_FRAC_MODE <= frac;
      @(negedge I_SYS_CLK);
   endtask : setin
   task automatic wr(input logic [2:0] c, input logic [4:0] a, input logic [23:0] d);
      q_rd.push_back(rdval(ptr));
      if (c == 3'h0) begin
         case (a)
            5'h00: begin
               if (d[5])
                  rst_regs();
               else
                  ptr = d[4:0];
            end
            5'h01: pwr = d;
            5'h02: refd = d;
            5'h03: intg = d;
            default: ;
         endcase
      end
      q_st.push_back(stval());
      u_pcrb_host_model.send({d, a, c});
   endtask : wr
   task automatic cmp_rd(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_rd
   task automatic cmp_st(input logic [41:0] got, input logic [41:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_st
   task automatic summarize();
      if (q_rd.size() != 0 || q_st.size() != 0) bad_count++;
      if (bad_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////
   // Watcher: each completed frame yields one read word and one output snapshot
   always @(u_pcrb_host_model.done) begin
      cmp_rd(u_pcrb_host_model.rd, q_rd.pop_front());
      cmp_st({O_CHIP_ENABLED, O_BLOCK_ON, O_REF_DIV, O_INT_DIV, O_REF_ERR, O_INT_ERR},
             q_st.pop_front());
   end
   initial begin
      #200us;
      bad_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge I_SYS_CLK);
      I_ARST_N <= 1'b1;
      repeat (6) @(posedge I_SYS_CLK);
      rst_regs();
      wr(3'h1, 5'h00, 24'h000001);
      wr(3'h0, 5'h00, 24'h000001);
      for (int k = 0; k < 8; k++) begin
         setin(k[2], 1'b1);
         wr(3'h0, 5'h01, (24'($random(seed)) & 24'hFFFFFC) | {22'h0, k[1:0]});
      end
      wr(3'h0, 5'h01, 24'h0000FC);
      wr(3'h5, 5'h01, 24'h000003);
      wr(3'h0, 5'h00, 24'h000002);
      wr(3'h0, 5'h02, 24'hFFC000);
      wr(3'h0, 5'h02, 24'h000001);
      wr(3'h0, 5'h02, 24'h003FFF);
      wr(3'h0, 5'h00, 24'h000003);
      for (int k = 0; k < 8; k++) begin
         setin(1'b1, iv[k][24]);
         wr(3'h0, 5'h03, iv[k][23:0]);
      end
      wr(3'h0, 5'h04, 24'($random(seed)));
      wr(3'h0, 5'h00, 24'h000005);
      wr(3'h0, 5'h00, 24'h000000);
      wr(3'h0, 5'h00, 24'h000020);
      wr(3'h0, 5'h00, 24'h000003);
      wr(3'h0, 5'h01, 24'($random(seed)));
      wr(3'h0, 5'h00, 24'h000001);
      @(posedge I_SYS_CLK);
      I_ARST_N <= 1'b0;
      repeat (5) @(posedge I_SYS_CLK);
      I_ARST_N <= 1'b1;
      repeat (6) @(posedge I_SYS_CLK);
      rst_regs();
      wr(3'h0, 5'h00, 24'h000001);
      wr(3'h0, 5'h00, 24'h000002);
      // Let the watcher take the last frame before the verdict
      repeat (2) @(posedge I_SYS_CLK);
      summarize();
   end
endmodule : test_pcrb_bank
`default_nettype wire
